// ===== core/lcdh_pkg.sv
// ==========================================================
// shared constants of the lcd host interface
package lcdh_pkg;
    // ==========================================================
    // widths and memory depths
    localparam int DATA_W = 8;
    localparam int AC_W = 7;
    localparam int DISP_DEPTH = 80;
    localparam int GLYPH_DEPTH = 64;
    localparam int ICON_DEPTH = 16;
    localparam logic [6:0] DISP_FIRST = 7'h00;
    localparam logic [6:0] DISP_LAST = 7'h4f;

    // ==========================================================
    // clock and busy timing
    localparam int CLK_NS = 100;
    localparam int BUSY_TIME_NS = 40000;
    localparam logic [8:0] BUSY_CYC = 9'((BUSY_TIME_NS + CLK_NS - 1) / CLK_NS);

    // ==========================================================
    // instruction fields
    localparam int FS_DL_BIT = 4;
    localparam int EM_ID_BIT = 1;

    // ==========================================================
    // serial frame: header byte then data byte
    localparam logic [3:0] SER_HDR_LAST = 4'h7;
    localparam logic [3:0] SER_FRAME_LAST = 4'hf;
    localparam int HDR_RW_BIT = 7;
    localparam int HDR_RS_BIT = 6;

    // ==========================================================
    // values after reset
    localparam logic RST_WIDTH8 = 1'b1;
    localparam logic RST_INC = 1'b1;
    localparam logic [6:0] RST_AC = 7'h00;

    // ==========================================================
    // extension driver scan
    localparam logic [6:0] EXT_FIRST_DOT = 7'h3c;
    localparam logic [6:0] EXT_LAST_DOT = 7'h63;
    localparam logic [6:0] EXT_DOTS_PER_CHAR = 7'h05;
    localparam logic [4:0] EXT_LAST_LINE = 5'h10;

    typedef enum logic [1:0] {TGT_DISP, TGT_GLYPH, TGT_ICON} lcdh_target_t;
    typedef enum logic [1:0] {EXT_IDLE, EXT_SHIFT, EXT_LATCH} lcdh_ext_state_t;
endpackage : lcdh_pkg

// ===== core/lcdh_host_if.sv
`timescale 1ns/1ps
module lcdh_host_if
    import lcdh_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic strobe_or_sclk,
    input wire logic iface_select,
    input wire logic regsel_or_chipsel,
    input wire logic rw_or_serial_in,
    input wire logic [7:0] data_bus_in,
    output logic [7:0] data_bus_out,
    output logic [7:0] data_bus_oe,
    input wire logic extension_enable,
    input wire logic instr_set_select,
    output logic ext_latch_clock,
    output logic ext_shift_clock,
    output logic ext_serial_data,
    output logic frame_alt,
    output logic busy_flag,
    output logic [6:0] ram_address_counter,
    output logic bus_width_bit
);
    // ==========================================================
    // pin synchronisers
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic e_d;
    logic wt_d;
    logic rt_d;
    logic s_wr_tgl;
    logic s_rd_tgl;
    wire [15:0] pin_raw = {s_rd_tgl, s_wr_tgl, instr_set_select, extension_enable, strobe_or_sclk,
                           rw_or_serial_in, regsel_or_chipsel, iface_select, data_bus_in};
    wire [7:0] db_s = sync2[7:0];
    wire im_s = sync2[8];
    wire rs_s = sync2[9];
    wire rw_s = sync2[10];
    wire e_s = sync2[11];
    wire ext_s = sync2[12];
    wire ie_s = sync2[13];
    wire wt_s = sync2[14];
    wire rt_s = sync2[15];

    // every pin and every toggle from the serial domain goes through two flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1 <= 16'h0000;
            sync2 <= 16'h0000;
            e_d <= 1'b0;
            wt_d <= 1'b0;
            rt_d <= 1'b0;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            e_d <= e_s;
            wt_d <= wt_s;
            rt_d <= rt_s;
        end
    end

    // ==========================================================
    // core state
    logic [7:0] dr;
    logic [7:0] ir;
    logic [6:0] ac;
    logic inc;
    lcdh_target_t target;
    logic [8:0] busy_cnt;
    logic nib;
    logic [3:0] hi_nib;
    logic [7:0] bus_out;
    logic [7:0] bus_oe;
    logic [7:0] snap_stat;
    logic [7:0] snap_dr;
    logic [7:0] disp_ram [DISP_DEPTH];
    logic [7:0] glyph_ram [GLYPH_DEPTH];
    logic [7:0] icon_ram [ICON_DEPTH];
    logic s_rs;
    logic [7:0] s_word;
    logic s_out;
    logic s_oe;

    // step the counter by one, wrapping within the target ram
    function automatic logic [6:0] step_ac(input lcdh_target_t t, input logic [6:0] a, input logic up);
        logic [6:0] r;
        r = a;
        case (t)
            TGT_DISP: begin
                if (up) r = (a >= DISP_LAST) ? DISP_FIRST : a + 7'h01;
                else r = (a == DISP_FIRST) ? DISP_LAST : a - 7'h01;
            end
            TGT_GLYPH: r = {1'b0, up ? a[5:0] + 6'h01 : a[5:0] - 6'h01};
            TGT_ICON: r = {3'h0, up ? a[3:0] + 4'h1 : a[3:0] - 4'h1};
            default: r = a;
        endcase
        return r;
    endfunction : step_ac

    // ==========================================================
    // access decode, bus and serial merged into one event stream
    wire width8 = bus_width_bit;
    wire ser_mode = ~im_s;
    wire bus_mode = im_s;
    wire e_fall = bus_mode & e_d & ~e_s;
    wire last_part = width8 | nib;
    wire bus_wr = e_fall & ~rw_s & last_part;
    wire bus_rd = e_fall & rw_s & last_part;
    wire [7:0] bus_wr_data = width8 ? db_s : {hi_nib, db_s[7:4]};
    wire ser_wr = ser_mode & (wt_s ^ wt_d);
    wire ser_rd = ser_mode & (rt_s ^ rt_d);
    wire ev_wr = bus_wr | ser_wr;
    wire ev_rd = bus_rd | ser_rd;
    wire ev_rs = ser_mode ? s_rs : rs_s;
    wire [7:0] ev_data = ser_mode ? s_word : bus_wr_data;
    wire ir_take = ev_wr & ~ev_rs & ~busy_flag;
    wire dr_wr = ev_wr & ev_rs;
    wire dr_rd = ev_rd & ev_rs;

    // instruction classes; encodings outside this set only make the block busy
    wire is_disp_set = ev_data[7];
    wire is_glyph_set = ev_data[7:6] == 2'b01;
    wire is_icon_set = ie_s & (ev_data[7:4] == 4'b0001);
    wire is_fset = ev_data[7:5] == 3'b001;
    wire is_entry = ev_data[7:2] == 6'b000001;
    wire addr_set = ir_take & (is_disp_set | is_glyph_set | is_icon_set);

    // new target and address from an address setting instruction
    wire [6:0] disp_addr = (ev_data[6:0] > DISP_LAST) ? DISP_FIRST : ev_data[6:0];
    wire lcdh_target_t new_tgt = is_disp_set ? TGT_DISP : (is_glyph_set ? TGT_GLYPH : TGT_ICON);
    wire [6:0] new_ac = is_disp_set ? disp_addr : (is_glyph_set ? {1'b0, ev_data[5:0]} : {3'h0, ev_data[3:0]});
    wire [6:0] ac_step = step_ac(target, ac, inc);
    wire lcdh_target_t fetch_tgt = addr_set ? new_tgt : target;
    wire [6:0] fetch_addr = addr_set ? new_ac : ac_step;
    wire [7:0] fetch_data = (fetch_tgt == TGT_DISP) ? disp_ram[fetch_addr] :
                            (fetch_tgt == TGT_GLYPH) ? glyph_ram[fetch_addr[5:0]] : icon_ram[fetch_addr[3:0]];

    // ==========================================================
    // holding registers, address counter and target selection
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ir <= 8'h00;
            dr <= 8'h00;
            ac <= RST_AC;
            inc <= RST_INC;
            target <= TGT_DISP;
            bus_width_bit <= RST_WIDTH8;
        end else if (ir_take) begin
            ir <= ev_data;
            if (addr_set) begin
                target <= new_tgt;
                ac <= new_ac;
                dr <= fetch_data;
            end
            if (is_fset) bus_width_bit <= ev_data[FS_DL_BIT];
            if (is_entry) inc <= ev_data[EM_ID_BIT];
        end else if (dr_wr) begin
            dr <= ev_data;
            ac <= ac_step;
        end else if (dr_rd) begin
            ac <= ac_step;
            dr <= fetch_data;
        end
    end

    // ram storage; the byte written lands at the counter value before the step
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < DISP_DEPTH; i++) disp_ram[i] <= 8'h00;
            for (int i = 0; i < GLYPH_DEPTH; i++) glyph_ram[i] <= 8'h00;
            for (int i = 0; i < ICON_DEPTH; i++) icon_ram[i] <= 8'h00;
        end else if (dr_wr) begin
            case (target)
                TGT_DISP: disp_ram[ac] <= ev_data;
                TGT_GLYPH: glyph_ram[ac[5:0]] <= ev_data;
                TGT_ICON: icon_ram[ac[3:0]] <= ev_data;
                default: ;
            endcase
        end
    end

    // busy window after each accepted instruction; host must poll it, nothing queues
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy_cnt <= 9'h000;
            busy_flag <= 1'b0;
        end else if (ir_take) begin
            busy_cnt <= BUSY_CYC;
            busy_flag <= 1'b1;
        end else if (busy_cnt != 9'h000) begin
            busy_cnt <= busy_cnt - 9'h001;
            if (busy_cnt == 9'h001) busy_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) ram_address_counter <= RST_AC;
        else ram_address_counter <= ac;
    end

    // ==========================================================
    // parallel bus: nibble pairing and read drive
    // instruction register never appears here, only status or data
    wire [7:0] rd_val = rs_s ? dr : {busy_flag, ac};
    wire [7:0] rd_lane = width8 ? rd_val : (nib ? {rd_val[3:0], 4'h0} : {rd_val[7:4], 4'h0});
    wire [7:0] rd_en = width8 ? 8'hff : 8'hf0;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            nib <= 1'b0;
            hi_nib <= 4'h0;
        end else if (!bus_mode || width8) begin
            nib <= 1'b0;
        end else if (e_fall) begin
            nib <= ~nib; // high nibble first, then low
            if (!nib && !rw_s) hi_nib <= db_s[7:4];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bus_out <= 8'h00;
            bus_oe <= 8'h00;
        end else begin
            bus_out <= rd_lane;
            bus_oe <= (bus_mode && e_s && rw_s) ? rd_en : 8'h00;
        end
    end

    // bit 0 carries the serial reply in serial mode, the upper lines stay off
    assign data_bus_out = {bus_out[7:1], ser_mode ? s_out : bus_out[0]};
    assign data_bus_oe = {bus_oe[7:1], ser_mode ? s_oe : bus_oe[0]};

    // snapshot frozen while chip select is low, so the serial side reads a steady word
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            snap_stat <= 8'h00;
            snap_dr <= 8'h00;
        end else if (rs_s || bus_mode) begin
            snap_stat <= {busy_flag, ac};
            snap_dr <= dr;
        end
    end

    // ==========================================================
    // serial link, clocked by the host's serial clock
    // frame state is cleared by chip select high, so no edge outside a frame matters
    wire s_rst_n = nrst & ~regsel_or_chipsel & ~iface_select;
    logic [3:0] s_cnt;
    logic [7:0] s_sh;
    logic [7:0] s_osh;
    logic s_rw;
    wire [7:0] s_byte = {s_sh[6:0], rw_or_serial_in};

    always_ff @(posedge strobe_or_sclk or negedge s_rst_n) begin
        if (!s_rst_n) begin
            s_cnt <= 4'h0;
            s_sh <= 8'h00;
            s_osh <= 8'h00;
            s_rw <= 1'b0;
            s_out <= 1'b0;
            s_oe <= 1'b0;
        end else begin
            s_cnt <= s_cnt + 4'h1;
            s_sh <= s_byte;
            if (s_cnt == SER_HDR_LAST) begin
                s_rw <= s_byte[HDR_RW_BIT];
                s_osh <= s_byte[HDR_RS_BIT] ? snap_dr : snap_stat;
                s_out <= s_byte[HDR_RS_BIT] ? snap_dr[7] : snap_stat[7];
                s_oe <= s_byte[HDR_RW_BIT];
            end else if (s_cnt == SER_FRAME_LAST) begin
                s_oe <= 1'b0;
            end else if (s_cnt > SER_HDR_LAST) begin
                s_osh <= {s_osh[6:0], 1'b0};
                s_out <= s_osh[6];
            end
        end
    end

    // results held across chip select so the core can pick them up after the frame
    always_ff @(posedge strobe_or_sclk or negedge nrst) begin
        if (!nrst) begin
            s_rs <= 1'b0;
            s_word <= 8'h00;
            s_wr_tgl <= 1'b0;
            s_rd_tgl <= 1'b0;
        end else if (s_cnt == SER_HDR_LAST) begin
            s_rs <= s_byte[HDR_RS_BIT];
        end else if (s_cnt == SER_FRAME_LAST) begin
            if (!s_rw) begin
                s_word <= s_byte;
                s_wr_tgl <= ~s_wr_tgl;
            end else begin
                s_rd_tgl <= ~s_rd_tgl;
            end
        end
    end

    // ==========================================================
    // extension driver scan: shift out dots from the 61st, latch per line
    lcdh_ext_state_t ext_state;
    logic [6:0] ext_dot;
    logic [4:0] ext_line;
    logic ext_phase;
    wire [6:0] ext_char = 7'(ext_dot / EXT_DOTS_PER_CHAR);
    wire [6:0] ext_col = 7'(ext_dot % EXT_DOTS_PER_CHAR);
    wire [7:0] ext_code = disp_ram[ext_char];
    wire ext_bit = ext_code[3'(7'h04 - ext_col)];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext_state <= EXT_IDLE;
            ext_dot <= EXT_FIRST_DOT;
            ext_line <= 5'h00;
            ext_phase <= 1'b0;
            ext_latch_clock <= 1'b0;
            ext_shift_clock <= 1'b0;
            ext_serial_data <= 1'b0;
            frame_alt <= 1'b0;
        end else if (!ext_s) begin
            ext_state <= EXT_IDLE; // quiet outputs save current with no extension fitted
            ext_latch_clock <= 1'b0;
            ext_shift_clock <= 1'b0;
            ext_serial_data <= 1'b0;
        end else begin
            case (ext_state)
                EXT_IDLE: begin
                    ext_dot <= EXT_FIRST_DOT;
                    ext_phase <= 1'b0;
                    ext_state <= EXT_SHIFT;
                end
                EXT_SHIFT: begin
                    ext_latch_clock <= 1'b0;
                    ext_phase <= ~ext_phase;
                    ext_shift_clock <= ~ext_phase;
                    if (!ext_phase) ext_serial_data <= ext_bit;
                    else if (ext_dot == EXT_LAST_DOT) ext_state <= EXT_LATCH;
                    else ext_dot <= ext_dot + 7'h01;
                end
                EXT_LATCH: begin
                    ext_shift_clock <= 1'b0;
                    ext_latch_clock <= 1'b1;
                    ext_dot <= EXT_FIRST_DOT;
                    ext_state <= EXT_SHIFT;
                    if (ext_line == EXT_LAST_LINE) begin
                        ext_line <= 5'h00;
                        frame_alt <= ~frame_alt;
                    end else begin
                        ext_line <= ext_line + 5'h01;
                    end
                end
                default: ext_state <= EXT_IDLE;
            endcase
        end
    end
endmodule : lcdh_host_if

// ===== tb/lcdh_host_if_properties.sv
`timescale 1ns/1ps
// ==========================================================
// port-level properties of the host interface
module lcdh_host_if_properties
    import lcdh_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic iface_select,
    input wire logic regsel_or_chipsel,
    input wire logic rw_or_serial_in,
    input wire logic [7:0] data_bus_oe,
    input wire logic ext_latch_clock,
    input wire logic frame_alt,
    input wire logic busy_flag,
    input wire logic bus_width_bit
);
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    logic [9:0] busy_len;

    // ==========================================================
    // length of the current busy stretch, read back at its end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) busy_len <= 10'h000;
        else busy_len <= busy_flag ? busy_len + 10'h001 : 10'h000;
    end

    // ==========================================================
    // assertions
    AST_BUSY_LEN: assert property ($fell(busy_flag) |-> busy_len == 10'(BUSY_CYC))
        else $error("busy stretch has the wrong length");
    AST_BUSY_MAX: assert property (busy_flag |-> busy_len < 10'(BUSY_CYC))
        else $error("busy held too long");
    AST_WR_NO_DRIVE: assert property ((iface_select && !rw_or_serial_in)[*6] |-> data_bus_oe == 8'h00)
        else $error("data lanes driven during a write");
    AST_LANES_8: assert property (iface_select[*4] ##0 bus_width_bit |-> data_bus_oe inside {8'h00, 8'hff})
        else $error("partial lanes driven in 8-bit mode");
    AST_LANES_4: assert property (iface_select[*4] ##0 !bus_width_bit |-> data_bus_oe inside {8'h00, 8'hf0})
        else $error("low lanes driven in 4-bit mode");
    AST_SER_UPPER: assert property ((!iface_select)[*4] |-> data_bus_oe[7:1] == 7'h00)
        else $error("upper lanes driven in serial mode");
    AST_SER_DESEL: assert property ((!iface_select && regsel_or_chipsel)[*3] |-> !data_bus_oe[0])
        else $error("serial output driven while deselected");
    AST_LATCH_PULSE: assert property (ext_latch_clock |=> !ext_latch_clock)
        else $error("latch clock longer than one cycle");
    AST_FRAME_ALT: assert property ($changed(frame_alt) |->
        ext_latch_clock || $past(ext_latch_clock) || $past(ext_latch_clock, 2))
        else $error("frame alternation moved away from a latch");

    // main scenarios reached
    cover property ($rose(busy_flag));
    cover property (!iface_select && data_bus_oe[0]);
    cover property (!bus_width_bit && data_bus_oe == 8'hf0);
    cover property ($changed(frame_alt));
endmodule : lcdh_host_if_properties

bind lcdh_host_if lcdh_host_if_properties u_props (.clk(clk), .nrst(nrst), .iface_select(iface_select),
    .regsel_or_chipsel(regsel_or_chipsel), .rw_or_serial_in(rw_or_serial_in), .data_bus_oe(data_bus_oe),
    .ext_latch_clock(ext_latch_clock), .frame_alt(frame_alt), .busy_flag(busy_flag),
    .bus_width_bit(bus_width_bit));

// ===== tb/lcdh_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// host processor model: parallel bus and serial link
module lcdh_host_model (
    input wire logic clk,
    input wire logic [7:0] dev_out,
    input wire logic [7:0] dev_oe,
    output logic strobe_or_sclk,
    output logic regsel_or_chipsel,
    output logic rw_or_serial_in,
    output logic [7:0] pin_level
);
    logic drive;
    logic [7:0] hd;
    // released lanes show the inverse of the last value so stale data never passes
    assign pin_level = (dev_oe & dev_out) | (~dev_oe & (drive ? hd : ~hd));
    initial begin
        strobe_or_sclk = 1'b0;
        regsel_or_chipsel = 1'b1;
        rw_or_serial_in = 1'b1;
        drive = 1'b0;
        hd = 8'h00;
    end

    // one bus access, two strobes on the upper lanes in 4-bit mode
    task automatic bus_xfer(input logic rs, input logic rw, input logic w8, input logic [7:0] d,
                            output logic [7:0] q);
        logic [3:0] nib;
        q = 8'h00;
        for (int n = 0; n < (w8 ? 1 : 2); n++) begin
            nib = (n == 0) ? d[7:4] : d[3:0];
            @(posedge clk);
            regsel_or_chipsel <= rs;
            rw_or_serial_in <= rw;
            drive <= !rw;
            hd <= w8 ? d : {nib, ~nib};
            repeat (2) @(posedge clk);
            strobe_or_sclk <= 1'b1;
            repeat (5) @(posedge clk);
            if (w8) q = pin_level;
            else if (n == 0) q[7:4] = pin_level[7:4];
            else q[3:0] = pin_level[7:4];
            strobe_or_sclk <= 1'b0;
            repeat (5) @(posedge clk);
            drive <= 1'b0;
        end
    endtask : bus_xfer

    // one serial frame: header then data, msb first, clock still outside the frame
    task automatic ser_xfer(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
        logic [15:0] f;
        f = {rw, rs, 6'h00, d};
        q = 8'h00;
        regsel_or_chipsel <= 1'b0;
        #400;
        for (int i = 15; i >= 0; i--) begin
            rw_or_serial_in <= f[i];
            #32;
            if (i < 8) q[i] = pin_level[0];
            strobe_or_sclk <= 1'b1;
            #32;
            strobe_or_sclk <= 1'b0;
        end
        rw_or_serial_in <= ~f[0];
        #640;
        regsel_or_chipsel <= 1'b1;
        #400;
    endtask : ser_xfer
endmodule : lcdh_host_model

// ===== tb/lcdh_host_if_bench.sv
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the lcd host interface
module lcdh_host_if_bench
    import lcdh_pkg::*;
;
    logic clk, nrst, iface_select, extension_enable, instr_set_select;
    logic strobe_or_sclk, regsel_or_chipsel, rw_or_serial_in;
    logic [7:0] pins, data_bus_out, data_bus_oe, q;
    logic ext_latch_clock, ext_shift_clock, ext_serial_data, frame_alt, busy_flag, bus_width_bit, fa_q, sh_q;
    logic [6:0] ram_address_counter, ac, a;
    logic ser, w8, inc;
    lcdh_target_t tgt;
    logic [7:0] mem [0:383];
    int bad_count = 0, samples_checked = 0, cyc = 0, latches = 0, flips = 0, shifts = 0;

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    lcdh_host_if uut (.clk(clk), .nrst(nrst), .strobe_or_sclk(strobe_or_sclk), .iface_select(iface_select),
        .regsel_or_chipsel(regsel_or_chipsel), .rw_or_serial_in(rw_or_serial_in), .data_bus_in(pins),
        .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe), .extension_enable(extension_enable),
        .instr_set_select(instr_set_select), .ext_latch_clock(ext_latch_clock),
        .ext_shift_clock(ext_shift_clock), .ext_serial_data(ext_serial_data), .frame_alt(frame_alt),
        .busy_flag(busy_flag), .ram_address_counter(ram_address_counter), .bus_width_bit(bus_width_bit));
    lcdh_host_model host (.clk(clk), .dev_out(data_bus_out), .dev_oe(data_bus_oe),
        .strobe_or_sclk(strobe_or_sclk), .regsel_or_chipsel(regsel_or_chipsel),
        .rw_or_serial_in(rw_or_serial_in), .pin_level(pins));

    // cycle ceiling and extension scan counts
    always @(posedge clk) begin
        cyc++;
        // every line shifts out the full run of dots before its latch
        if (ext_shift_clock === 1'b1 && sh_q !== 1'b1) shifts++;
        sh_q = ext_shift_clock;
        if (ext_latch_clock === 1'b1) begin
            latches++;
            check("shifts per line", 8'(shifts), 8'(EXT_LAST_DOT - EXT_FIRST_DOT + 7'h01));
            shifts = 0;
        end
        if (frame_alt !== fa_q) flips++;
        fa_q = frame_alt;
        if (cyc == 60000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test

    // next counter value, wrapping inside the addressed ram
    function automatic logic [6:0] nxt(input logic [6:0] v);
        case (tgt)
            TGT_DISP: return inc ? (v == DISP_LAST ? DISP_FIRST : v + 7'h01) : (v == DISP_FIRST ? DISP_LAST : v - 7'h01);
            TGT_GLYPH: return {1'b0, 6'(inc ? v + 7'h01 : v - 7'h01)};
            default: return {3'h0, 4'(inc ? v + 7'h01 : v - 7'h01)};
        endcase
    endfunction : nxt

    function automatic int key();
        return int'(tgt) * 128 + int'(ac);
    endfunction : key

    task automatic xfer(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] r);
        if (ser) host.ser_xfer(rs, rw, d, r);
        else host.bus_xfer(rs, rw, w8, d, r);
    endtask : xfer

    // status poll until idle; returns the last status word
    task automatic ready(output logic [7:0] s);
        int n;
        n = 0;
        do begin
            xfer(1'b0, 1'b1, 8'h00, s);
            n++;
        end while (s[7] !== 1'b0 && n < 80);
    endtask : ready

    task automatic chk_status();
        ready(q);
        check("status", q, {1'b0, ac});
        check("counter", {1'b0, ram_address_counter}, {1'b0, ac});
    endtask : chk_status

    task automatic instr(input logic [7:0] c);
        ready(q);
        xfer(1'b0, 1'b0, c, q);
    endtask : instr

    task automatic set_addr(input lcdh_target_t t, input logic [6:0] v);
        tgt = t;
        ac = v;
        instr(t == TGT_DISP ? {1'b1, v} : t == TGT_GLYPH ? {2'b01, v[5:0]} : {4'h1, v[3:0]});
    endtask : set_addr

    task automatic wr_data(input logic [7:0] d);
        ready(q);
        xfer(1'b1, 1'b0, d, q);
        mem[key()] = d;
        ac = nxt(ac);
        chk_status();
    endtask : wr_data

    task automatic rd_data();
        ready(q);
        xfer(1'b1, 1'b1, 8'h00, q);
        check("data", q, mem[key()]);
        ac = nxt(ac);
        chk_status();
    endtask : rd_data

    // busy refusal: a second instruction while busy leaves the counter alone
    task automatic refuse_test();
        set_addr(TGT_DISP, 7'h05);
        check("busy", {7'h00, busy_flag}, 8'h01);
        xfer(1'b0, 1'b0, 8'h8a, q);
        chk_status();
    endtask : refuse_test

    initial begin
        nrst = 1'b0;
        iface_select = 1'b1;
        extension_enable = 1'b0;
        instr_set_select = 1'b1;
        fa_q = 1'b0;
        ser = 1'b0;
        w8 = 1'b1;
        inc = RST_INC;
        ac = RST_AC;
        tgt = TGT_DISP;
        foreach (mem[i]) mem[i] = 8'h00;
        void'($urandom(32'h61cf4ca0));
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        extension_enable <= 1'b1;
        repeat (3) @(posedge clk);
        check("width", {7'h00, bus_width_bit}, {7'h00, RST_WIDTH8});
        check("counter", {1'b0, ram_address_counter}, {1'b0, RST_AC});
        chk_status();
        $display("test reset done");
        // each ram: random writes, then read back from the same start
        for (int t = 0; t < 3; t++) begin
            a = 7'($urandom % (t == 0 ? 80 : t == 1 ? 64 : 16));
            set_addr(lcdh_target_t'(t), a);
            repeat (3) wr_data(8'($urandom));
            set_addr(lcdh_target_t'(t), a);
            repeat (3) rd_data();
        end
        $display("test ram targets done");
        refuse_test();
        // wrap at both ends of the one-line display range
        set_addr(TGT_DISP, DISP_LAST);
        wr_data(8'($urandom));
        instr(8'h04);
        inc = 1'b0;
        set_addr(TGT_DISP, DISP_FIRST);
        wr_data(8'($urandom));
        instr(8'h06);
        inc = 1'b1;
        $display("test wrap done");
        // narrow bus: nibbles on the upper lanes only
        instr(8'h20);
        w8 = 1'b0;
        chk_status();
        check("width", {7'h00, bus_width_bit}, 8'h00);
        a = ac;
        wr_data(8'($urandom));
        set_addr(TGT_DISP, a);
        rd_data();
        instr(8'h30);
        w8 = 1'b1;
        chk_status();
        check("width", {7'h00, bus_width_bit}, 8'h01);
        $display("test narrow bus done");
        // serial link
        iface_select <= 1'b0;
        repeat (4) @(posedge clk);
        ser = 1'b1;
        a = 7'($urandom % 80);
        set_addr(TGT_DISP, a);
        wr_data(8'($urandom));
        set_addr(TGT_DISP, a);
        rd_data();
        refuse_test();
        $display("test serial done");
        // extension scan: alternation flips once every seventeen lines
        @(posedge clk iff ext_latch_clock === 1'b1);
        @(posedge clk iff ext_shift_clock === 1'b1);
        a = EXT_FIRST_DOT / EXT_DOTS_PER_CHAR;
        check("first dot", {7'h00, ext_serial_data}, {7'h00, mem[a][3'(EXT_DOTS_PER_CHAR - 7'h01)]});
        repeat (3) @(posedge clk);
        check("frame flips", 8'(flips), 8'(latches / 17));
        check("lines seen", 8'(latches > 17), 8'h01);
        $display("test extension done");
        end_of_test();
    end
endmodule : lcdh_host_if_bench
